// File: core/gpio_consts.vh
// Purpose: shared constants of the three-port general-purpose I/O block
// Assumes: 16-bit special function register address space, byte data
// Notes:   port latch offsets are a local choice inside the short-direct area
`ifndef GPIO_CONSTS_VH
`define GPIO_CONSTS_VH

`define PORT_WIDTH          8
`define ADDR_WIDTH          16

`define ADDR_PORT0_DIR      16'hFF20
`define ADDR_PORT2_DIR      16'hFF22
`define ADDR_PORT4_DIR      16'hFF24
`define ADDR_PORT0_PUP      16'hFF30
`define ADDR_PORT4_PUP      16'hFF34
`define ADDR_PORT0_DATA     16'hFF00
`define ADDR_PORT2_DATA     16'hFF02
`define ADDR_PORT4_DATA     16'hFF04

`define DIR_RESET           8'hFF
`define PUP_RESET           8'h00
`define LATCH_RESET         8'h00
`define UNMAPPED_READ       8'h00

`endif

// File: core/pin_sync.v
// Purpose: two-stage synchroniser for a group of pin inputs
// Assumes: pins are asynchronous to sys_clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter WIDTH = 8
) (
	input  wire             sys_clk,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] pin_async,
	output reg  [WIDTH-1:0] pin_sync_out
);

	reg [WIDTH-1:0] meta_r;

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			meta_r       <= {WIDTH{1'b0}};
			pin_sync_out <= {WIDTH{1'b0}};
		end else begin
			meta_r       <= pin_async;
			pin_sync_out <= meta_r;
		end
	end

endmodule

`default_nettype wire

// File: core/port_cell.v
// Purpose: one 8-bit port: output latch, direction, pull-up, read mux
// Assumes: bus write and read strobes are one-cycle pulses on sys_clk
// Notes:   pull-up control is absent when HAS_PULLUP is 0
`timescale 1ns/1ps
`include "gpio_consts.vh"
`default_nettype none

module port_cell #(
	parameter WIDTH      = 8,
	parameter HAS_PULLUP = 1
) (
	input  wire             sys_clk,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] wr_data,
	input  wire             latch_wr,
	input  wire             dir_wr,
	input  wire             pup_wr,
	input  wire [WIDTH-1:0] pin_level,
	output reg  [WIDTH-1:0] latch_r,
	output reg  [WIDTH-1:0] dir_r,
	output reg  [WIDTH-1:0] pup_r,
	output wire [WIDTH-1:0] port_read,
	output wire [WIDTH-1:0] pin_out,
	output wire [WIDTH-1:0] pin_oe,
	output wire [WIDTH-1:0] pullup_on
);

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			latch_r <= `LATCH_RESET;
			dir_r   <= `DIR_RESET;
			pup_r   <= `PUP_RESET;
		end else begin
			if (latch_wr) begin
				latch_r <= wr_data;
			end
			if (dir_wr) begin
				dir_r <= wr_data;
			end
			if (pup_wr && (HAS_PULLUP != 0)) begin
				pup_r <= wr_data;
			end
		end
	end

	assign pin_oe    = ~dir_r;
	assign pin_out   = latch_r;
	assign port_read = (latch_r & ~dir_r) | (pin_level & dir_r);
	assign pullup_on = pup_r & dir_r;

endmodule

`default_nettype wire

// File: core/gpio_ports.v
// Purpose: general-purpose I/O logic for ports 0, 2 and 4
// Assumes: CPU bus is a simple SFR strobe interface on sys_clk
// Notes:   read-modify-write is a read then a write by the CPU
//
// Overview of operation
// - eight-bit ports, per-bit direction register
// - direction 0 output, 1 input
// - reset sets all directions to input
// - pull-up enables on ports 0, 4 only
// - pull-up bit 1 requests pull-up
// - pull-up only on input-mode pins
// - reset clears both pull-up registers
// - output mode: latch drives pin, held
// - input mode: latch written, pin unchanged
// - output-mode read returns latch
// - input-mode read returns pin level
// - output-mode modify writes latch and pins
// - input-mode modify may leave latch undefined
// - bit operations touch whole port byte
// - port-4 output change raises interrupt request
// - port 0 also enters input on reset
`timescale 1ns/1ps
`include "gpio_consts.vh"
`default_nettype none

module gpio_ports #(
	parameter WIDTH = `PORT_WIDTH
) (
	input  wire                   sys_clk,
	input  wire                   reset_n,
	input  wire [`ADDR_WIDTH-1:0] sfr_addr,
	input  wire [WIDTH-1:0]       sfr_wdata,
	input  wire                   sfr_wr,
	input  wire                   sfr_rd,
	output reg  [WIDTH-1:0]       sfr_rdata,
	input  wire [WIDTH-1:0]       port0_in,
	output wire [WIDTH-1:0]       port0_out,
	output wire [WIDTH-1:0]       port0_oe,
	output wire [WIDTH-1:0]       port0_pullup,
	input  wire [WIDTH-1:0]       port2_in,
	output wire [WIDTH-1:0]       port2_out,
	output wire [WIDTH-1:0]       port2_oe,
	input  wire [WIDTH-1:0]       port4_in,
	output wire [WIDTH-1:0]       port4_out,
	output wire [WIDTH-1:0]       port4_oe,
	output wire [WIDTH-1:0]       port4_pullup,
	output wire [WIDTH-1:0]       port4_level,
	output reg                    port4_change
);

	wire [WIDTH-1:0] p0_sync;
	wire [WIDTH-1:0] p2_sync;
	wire [WIDTH-1:0] p4_sync;
	wire [WIDTH-1:0] p0_latch;
	wire [WIDTH-1:0] p2_latch;
	wire [WIDTH-1:0] p4_latch;
	wire [WIDTH-1:0] p0_dir;
	wire [WIDTH-1:0] p2_dir;
	wire [WIDTH-1:0] p4_dir;
	wire [WIDTH-1:0] p0_pup;
	wire [WIDTH-1:0] p4_pup;
	wire [WIDTH-1:0] p0_read;
	wire [WIDTH-1:0] p2_read;
	wire [WIDTH-1:0] p4_read;
	wire [WIDTH-1:0] p4_drive;
	wire             sel_p0_data;
	wire             sel_p2_data;
	wire             sel_p4_data;
	wire             sel_p0_dir;
	wire             sel_p2_dir;
	wire             sel_p4_dir;
	wire             sel_p0_pup;
	wire             sel_p4_pup;
	wire             wr_p0_data;
	wire             wr_p2_data;
	wire             wr_p4_data;
	wire             wr_p0_dir;
	wire             wr_p2_dir;
	wire             wr_p4_dir;
	wire             wr_p0_pup;
	wire             wr_p4_pup;
	reg  [WIDTH-1:0] p4_drive_r;
	reg  [WIDTH-1:0] sfr_rdata_nxt;

	function hit;
		input [`ADDR_WIDTH-1:0] a;
		input [`ADDR_WIDTH-1:0] target;
		begin
			hit = (a == target);
		end
	endfunction

	// exact decode: aliases of a register would let stray writes land
	assign sel_p0_data = hit(sfr_addr, `ADDR_PORT0_DATA);
	assign sel_p2_data = hit(sfr_addr, `ADDR_PORT2_DATA);
	assign sel_p4_data = hit(sfr_addr, `ADDR_PORT4_DATA);
	assign sel_p0_dir  = hit(sfr_addr, `ADDR_PORT0_DIR);
	assign sel_p2_dir  = hit(sfr_addr, `ADDR_PORT2_DIR);
	assign sel_p4_dir  = hit(sfr_addr, `ADDR_PORT4_DIR);
	assign sel_p0_pup  = hit(sfr_addr, `ADDR_PORT0_PUP);
	assign sel_p4_pup  = hit(sfr_addr, `ADDR_PORT4_PUP);

	// write strobes, one cycle each
	assign wr_p0_data  = sfr_wr & sel_p0_data;
	assign wr_p2_data  = sfr_wr & sel_p2_data;
	assign wr_p4_data  = sfr_wr & sel_p4_data;
	assign wr_p0_dir   = sfr_wr & sel_p0_dir;
	assign wr_p2_dir   = sfr_wr & sel_p2_dir;
	assign wr_p4_dir   = sfr_wr & sel_p4_dir;
	assign wr_p0_pup   = sfr_wr & sel_p0_pup;
	assign wr_p4_pup   = sfr_wr & sel_p4_pup;

	// pins are asynchronous: two flops before any use
	pin_sync #(.WIDTH(WIDTH)) u_sync0 (
		.sys_clk      (sys_clk),
		.reset_n      (reset_n),
		.pin_async    (port0_in),
		.pin_sync_out (p0_sync)
	);

	pin_sync #(.WIDTH(WIDTH)) u_sync2 (
		.sys_clk      (sys_clk),
		.reset_n      (reset_n),
		.pin_async    (port2_in),
		.pin_sync_out (p2_sync)
	);

	pin_sync #(.WIDTH(WIDTH)) u_sync4 (
		.sys_clk      (sys_clk),
		.reset_n      (reset_n),
		.pin_async    (port4_in),
		.pin_sync_out (p4_sync)
	);

	port_cell #(.WIDTH(WIDTH), .HAS_PULLUP(1)) u_port0 (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.wr_data   (sfr_wdata),
		.latch_wr  (wr_p0_data),
		.dir_wr    (wr_p0_dir),
		.pup_wr    (wr_p0_pup),
		.pin_level (p0_sync),
		.latch_r   (p0_latch),
		.dir_r     (p0_dir),
		.pup_r     (p0_pup),
		.port_read (p0_read),
		.pin_out   (port0_out),
		.pin_oe    (port0_oe),
		.pullup_on (port0_pullup)
	);

	port_cell #(.WIDTH(WIDTH), .HAS_PULLUP(0)) u_port2 (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.wr_data   (sfr_wdata),
		.latch_wr  (wr_p2_data),
		.dir_wr    (wr_p2_dir),
		.pup_wr    (1'b0),
		.pin_level (p2_sync),
		.latch_r   (p2_latch),
		.dir_r     (p2_dir),
		.pup_r     (),
		.port_read (p2_read),
		.pin_out   (port2_out),
		.pin_oe    (port2_oe),
		.pullup_on ()
	);

	port_cell #(.WIDTH(WIDTH), .HAS_PULLUP(1)) u_port4 (
		.sys_clk   (sys_clk),
		.reset_n   (reset_n),
		.wr_data   (sfr_wdata),
		.latch_wr  (wr_p4_data),
		.dir_wr    (wr_p4_dir),
		.pup_wr    (wr_p4_pup),
		.pin_level (p4_sync),
		.latch_r   (p4_latch),
		.dir_r     (p4_dir),
		.pup_r     (p4_pup),
		.port_read (p4_read),
		.pin_out   (port4_out),
		.pin_oe    (port4_oe),
		.pullup_on (port4_pullup)
	);

	// level seen by interrupt logic
	// driven bits follow the latch, so an output change looks like an edge
	assign p4_drive    = p4_latch & ~p4_dir;
	assign port4_level = p4_drive | (p4_sync & p4_dir);

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			p4_drive_r   <= `LATCH_RESET;
			port4_change <= 1'b0;
		end else begin
			p4_drive_r   <= p4_drive;
			port4_change <= |(p4_drive ^ p4_drive_r);
		end
	end

	// input latch follows pin
	// modify ops read this value then write it back, so input bits
	// pick up the pin level: their old latch contents are not preserved
	always @* begin
		sfr_rdata_nxt = `UNMAPPED_READ;
		case (sfr_addr)
			`ADDR_PORT0_DATA: sfr_rdata_nxt = p0_read;
			`ADDR_PORT2_DATA: sfr_rdata_nxt = p2_read;
			`ADDR_PORT4_DATA: sfr_rdata_nxt = p4_read;
			`ADDR_PORT0_DIR:  sfr_rdata_nxt = p0_dir;
			`ADDR_PORT2_DIR:  sfr_rdata_nxt = p2_dir;
			`ADDR_PORT4_DIR:  sfr_rdata_nxt = p4_dir;
			`ADDR_PORT0_PUP:  sfr_rdata_nxt = p0_pup;
			`ADDR_PORT4_PUP:  sfr_rdata_nxt = p4_pup;
			default:          sfr_rdata_nxt = `UNMAPPED_READ;
		endcase
	end

	always @(posedge sys_clk) begin
		if (!reset_n) begin
			sfr_rdata <= `UNMAPPED_READ;
		end else if (sfr_rd) begin
			sfr_rdata <= sfr_rdata_nxt;
		end
	end

endmodule

`default_nettype wire

// File: dv/pin_model.sv
// Purpose: outside pins of one port with on-chip pull-up network
// Assumes: ext is what outside circuitry puts on a released pin
// Notes:   a pulled-up input reads high whatever ext holds
`timescale 1ns/1ps
`default_nettype none
module pin_model (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pu_en,
	input  wire logic [7:0] ext,
	output wire logic [7:0] level
);
	assign level = (pin_oe & pin_out) | (~pin_oe & (pu_en | ext));
endmodule
`default_nettype wire

// File: dv/gpio_ports_checker.sv
// Purpose: port-level checks of the three-port I/O block
// Assumes: byte-wide ports, one clock
// Notes:   input-mode latch contents after modify are left alone
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_checker (
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic [15:0] sfr_addr,
	input wire logic [7:0]  sfr_wdata,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_rdata,
	input wire logic [7:0]  port0_out,
	input wire logic [7:0]  port0_oe,
	input wire logic [7:0]  port0_pullup,
	input wire logic [7:0]  port4_out,
	input wire logic [7:0]  port4_oe,
	input wire logic [7:0]  port4_pullup,
	input wire logic        port4_change
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence p4_wr;
		sfr_wr && sfr_addr == 16'hFF04;
	endsequence
	sequence p4_drive_change;
		p4_wr and ((sfr_wdata ^ port4_out) & port4_oe) != 8'h00;
	endsequence
	a_reset_all_input: assert property ($rose(reset_n) |-> port0_oe == 8'h00
		&& port4_oe == 8'h00 && port0_pullup == 8'h00 && port4_pullup == 8'h00)
		else $error("pins not released after reset");
	a_pup0_input_only: assert property ((port0_pullup & port0_oe) == 8'h00)
		else $error("port0 pull-up on driven pin");
	a_pup4_input_only: assert property ((port4_pullup & port4_oe) == 8'h00)
		else $error("port4 pull-up on driven pin");
	a_dir4_write: assert property (sfr_wr && sfr_addr == 16'hFF24
		|=> port4_oe == ~$past(sfr_wdata)) else $error("port4 enable not from direction");
	a_latch4_write: assert property (p4_wr |=> port4_out == $past(sfr_wdata))
		else $error("port4 latch not written");
	a_latch0_hold: assert property (!(sfr_wr && sfr_addr == 16'hFF00) |=> $stable(port0_out))
		else $error("port0 latch moved without write");
	a_read_out_latch: assert property (sfr_rd && sfr_addr == 16'hFF04 && port4_oe == 8'hFF
		|=> sfr_rdata == $past(port4_out)) else $error("output read not latch");
	a_rdata_held: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without read");
	a_change_flag: assert property (p4_drive_change |-> ##[1:2] port4_change)
		else $error("no change pulse on port4");
endmodule
bind gpio_ports gpio_ports_checker u_chk (.sys_clk, .reset_n, .sfr_addr, .sfr_wdata, .sfr_wr,
	.sfr_rd, .sfr_rdata, .port0_out, .port0_oe, .port0_pullup, .port4_out, .port4_oe,
	.port4_pullup, .port4_change);
`default_nettype wire

// File: dv/tb_top.sv
// Purpose: register-level tests of the three-port I/O block
// Assumes: strobes driven on falling edge, one access per task
// Notes:   pin reads wait out the two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        sys_clk, reset_n, sfr_wr, sfr_rd;
	logic [15:0] sfr_addr;
	logic [7:0]  sfr_wdata, ext0, ext2, ext4, rv;
	wire  [7:0]  sfr_rdata, p0i, p0o, p0e, p0u, p2i, p2o, p2e, p4i, p4o, p4e, p4u, p4l;
	wire         p4c;
	int          mismatches, n_tests, cycles, pulses;
	logic [15:0] ra [5] = '{16'hFF20, 16'hFF22, 16'hFF24, 16'hFF30, 16'hFF34};
	logic [7:0]  re [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00};
	gpio_ports uut (.sys_clk(sys_clk), .reset_n(reset_n), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.port0_in(p0i), .port0_out(p0o), .port0_oe(p0e), .port0_pullup(p0u),
		.port2_in(p2i), .port2_out(p2o), .port2_oe(p2e), .port4_in(p4i), .port4_out(p4o),
		.port4_oe(p4e), .port4_pullup(p4u), .port4_level(p4l), .port4_change(p4c));
	pin_model m0 (.pin_out(p0o), .pin_oe(p0e), .pu_en(p0u), .ext(ext0), .level(p0i));
	// no pull-up network on port 2
	pin_model m2 (.pin_out(p2o), .pin_oe(p2e), .pu_en(8'h00), .ext(ext2), .level(p2i));
	pin_model m4 (.pin_out(p4o), .pin_oe(p4e), .pu_en(p4u), .ext(ext4), .level(p4i));
	initial begin
		sys_clk = 0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic conclude;
		if (mismatches == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// run needs about 60 cycles
	always @(posedge sys_clk) begin
		cycles++;
		pulses += (reset_n && p4c === 1'b1);
		if (cycles == 2000) begin
			mismatches++;
			conclude;
		end
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one-cycle strobe; a gap cycle keeps back-to-back calls apart
	task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = w;
		sfr_rd = !w;
		@(negedge sys_clk);
		sfr_wr = 0;
		sfr_rd = 0;
		rv = sfr_rdata;
	endtask
	task automatic rdc(input logic [15:0] a, input logic [7:0] e, input string what);
		acc(0, a, 8'h00);
		chk(what, rv, e);
	endtask
	initial begin
		{reset_n, sfr_wr, sfr_rd} = 3'h0;
		sfr_addr = 16'h0000;
		sfr_wdata = 8'h00;
		{ext0, ext2, ext4} = {8'h00, 8'hC3, 8'h00};
		{mismatches, n_tests, cycles, pulses} = 0;
		repeat (5) @(negedge sys_clk);
		reset_n = 1;
		for (int i = 0; i < 5; i++) rdc(ra[i], re[i], "reset register");
		chk("enables after reset", p0e | p2e | p4e, 8'h00);
		chk("latches after reset", p0o | p2o | p4o, 8'h00);
		acc(1, 16'hFF30, 8'h0F);
		acc(1, 16'hFF20, 8'h3C);
		chk("port0 enable", p0e, 8'hC3);
		chk("port0 pull-up", p0u, 8'h0C);
		repeat (3) @(negedge sys_clk);
		rdc(16'hFF00, 8'h0C, "port0 mixed read");
		acc(1, 16'hFF02, 8'h5A);
		chk("port2 latch input mode", p2o, 8'h5A);
		chk("port2 enable input mode", p2e, 8'h00);
		acc(1, 16'hFF22, 8'hF0);
		chk("port2 driven bits", p2o & p2e, 8'h0A);
		repeat (3) @(negedge sys_clk);
		rdc(16'hFF02, 8'hCA, "port2 mixed read");
		chk("port2 latch after read", p2o, 8'h5A);
		acc(1, 16'hFF24, 8'h00);
		acc(1, 16'hFF04, 8'h11);
		rdc(16'hFF04, 8'h11, "port4 output read");
		acc(1, 16'hFF04, rv + 8'h01);
		chk("port4 modify result", p4o, 8'h12);
		acc(1, 16'hFF04, 8'h12);
		repeat (2) @(negedge sys_clk);
		chk("port4 change pulses", pulses[7:0], 8'h02);
		acc(1, 16'hFF34, 8'hFF);
		acc(1, 16'hFF24, 8'hF0);
		chk("port4 pull-up", p4u, 8'hF0);
		acc(1, 16'hFF32, 8'hAA);
		rdc(16'hFF32, 8'h00, "port2 pull-up place");
		rdc(16'hFF22, 8'hF0, "port2 direction");
		chk("port4 interrupt level", p4l, 8'hF2);
		acc(1, 16'hFF24, 8'hFF);
		chk("port4 key-return inputs", p4e, 8'h00);
		chk("port4 pull-up all inputs", p4u, 8'hFF);
		conclude;
	end
endmodule
`default_nettype wire
